/* design/arcc_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the rate and clock block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: counts of conversion length are in modulator ticks
`ifndef ARCC_CFG_SVH
`define ARCC_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ARCC_ADDR_W 8
`define ARCC_OFF_CTRL 8'h00
`define ARCC_OFF_CMD 8'h04
`define ARCC_OFF_STATUS 8'h08
`define ARCC_OFF_MASK 8'h0C
`define ARCC_OFF_DATA 8'h10
`define ARCC_OFF_AUXDIR 8'h14
`define ARCC_OFF_AUXOUT 8'h18
`define ARCC_OFF_AUXIN 8'h1C
`define ARCC_OFF_SERIAL 8'h20

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ARCC_CTRL_W 5
`define ARCC_CTRL_RST 5'h00
`define ARCC_CMD_START_BIT 3
`define ARCC_STS_CONV 0
`define ARCC_STS_RX 1
`define ARCC_STS_W 2
`define ARCC_AUX_N 4
`define ARCC_RX_BITS 8
`define ARCC_RES_BITS 24

// ----------------------------------------
// timing
// ----------------------------------------
`define ARCC_PCLK_HZ 125000000
`define ARCC_OSC_HI_HZ 2457600
`define ARCC_OSC_LO_HZ 2048000
`define ARCC_NCO_INC(f) (((64'(f)) << 32) / 64'(`ARCC_PCLK_HZ))
`define ARCC_MOD_DIV 10
`define ARCC_SETTLE_CONV 3
`define ARCC_SC_LEN0 245760
`define ARCC_SC_LEN1 98304
`define ARCC_SC_LEN2 49152
`define ARCC_SC_LEN3 24576
`define ARCC_SC_LEN4 16384
`define ARCC_SC_LEN5 8192
`define ARCC_SC_LEN6 4096
`define ARCC_SC_LEN7 2048
`define ARCC_CC_LEN0 4096
`define ARCC_CC_LEN1 2048
`define ARCC_CC_LEN2 1024
`define ARCC_CC_LEN3 512

`endif

/* design/arcc_pkg.sv */
// Purpose: types of the rate and clock block
// Assumes: constants live in arcc_cfg.svh
// Notes: control word layout matches the control register, msb first
package arcc_pkg;

  typedef logic [2:0] arcc_rate_t;

  typedef struct packed {
    logic input_buffer_en;
    logic single_conv_sel;
    logic ext_timebase_sel;
    logic unipolar_sel;
    logic line_freq_sel;
  } arcc_ctrl_t;

endpackage

/* design/arcc_time_if.sv */
// Purpose: link between register side and timebase
// Assumes: one clock, pclk
// Notes: restart and conv_done are one-cycle pulses
`timescale 1ns/10ps
interface arcc_time_if;
  logic ext_sel;
  logic line_sel;
  logic single_sel;
  arcc_pkg::arcc_rate_t rate;
  logic run;
  logic restart;
  logic mod_tick;
  logic conv_done;

  modport ctrl (output ext_sel, line_sel, single_sel, rate, run, restart,
                input mod_tick, conv_done);
  modport timer (input ext_sel, line_sel, single_sel, rate, run, restart,
                 output mod_tick, conv_done);
endinterface

/* design/arcc_timebase.sv */
// Purpose: system timebase, modulator tick and conversion period
// Assumes: external clock pin is asynchronous and far slower than pclk
// Notes: internal oscillator is emulated by a phase accumulator, so ticks jitter by one pclk
`timescale 1ns/10ps
`include "arcc_cfg.svh"
module arcc_timebase #(
  parameter int RATE_SHIFT = 0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // external timebase pin
  input wire logic ext_clk,
  // control side
  arcc_time_if.timer tif
);
  localparam logic [31:0] INC_HI = 32'(`ARCC_NCO_INC(`ARCC_OSC_HI_HZ));
  localparam logic [31:0] INC_LO = 32'(`ARCC_NCO_INC(`ARCC_OSC_LO_HZ));
  localparam logic [3:0] DIV_LAST = 4'(`ARCC_MOD_DIV - 1);

  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [31:0] acc_q, acc_d, inc;
  logic [3:0] div_q, div_d;
  logic [17:0] per_q, per_d, target;
  logic done_q, done_d, tick_q, tick_d;
  logic carry, sys_tick, mod_tick;

  function automatic logic [17:0] conv_len(input logic single, input logic [2:0] rate);
    logic [17:0] len;
    len = 18'(`ARCC_CC_LEN0);
    if (single) begin
      case (rate)
        3'h0: len = 18'(`ARCC_SC_LEN0);
        3'h1: len = 18'(`ARCC_SC_LEN1);
        3'h2: len = 18'(`ARCC_SC_LEN2);
        3'h3: len = 18'(`ARCC_SC_LEN3);
        3'h4: len = 18'(`ARCC_SC_LEN4);
        3'h5: len = 18'(`ARCC_SC_LEN5);
        3'h6: len = 18'(`ARCC_SC_LEN6);
        default: len = 18'(`ARCC_SC_LEN7);
      endcase
    end else begin
      // low codes in continuous mode fold onto 100..111
      case (rate[1:0])
        2'h0: len = 18'(`ARCC_CC_LEN0);
        2'h1: len = 18'(`ARCC_CC_LEN1);
        2'h2: len = 18'(`ARCC_CC_LEN2);
        default: len = 18'(`ARCC_CC_LEN3);
      endcase
    end
    return len;
  endfunction

  always_comb begin
    // (R7) oscillator frequency select
    inc = tif.line_sel ? INC_LO : INC_HI;
    {carry, acc_d} = {1'b0, acc_q} + {1'b0, inc};
    // (R5) external pin as timebase
    // (R6) rate follows the supplied clock
    sys_tick = tif.ext_sel ? (ext_s2_q & ~ext_s3_q) : carry;
    // (R8) modulator clock divider
    mod_tick = sys_tick && (div_q == DIV_LAST);
    div_d = div_q;
    if (tif.restart) begin
      // a start lines up with a whole modulator period, else a one-shot runs short
      div_d = 4'h0;
    end else if (sys_tick) begin
      div_d = mod_tick ? 4'h0 : div_q + 4'h1;
    end
    // (R11) (R12) conversion length from rate code
    target = conv_len(tif.single_sel, tif.rate) >> RATE_SHIFT;
    if (target == 18'h0) begin
      target = 18'h1;
    end
    per_d = per_q;
    done_d = 1'b0;
    if (tif.restart || !tif.run) begin
      per_d = 18'h0;
    end else if (mod_tick) begin
      if (per_q == target - 18'h1) begin
        per_d = 18'h0;
        done_d = 1'b1;
      end else begin
        per_d = per_q + 18'h1;
      end
    end
    tick_d = mod_tick;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      acc_q <= 32'h0;
      div_q <= 4'h0;
      per_q <= 18'h0;
      done_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      acc_q <= acc_d;
      div_q <= div_d;
      per_q <= per_d;
      done_q <= done_d;
      tick_q <= tick_d;
    end
  end

  assign tif.mod_tick = tick_q;
  assign tif.conv_done = done_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  osc_step_a: assert property ( // (R7)
    !tif.ext_sel |=> acc_q == 32'($past(acc_q) + ($past(tif.line_sel) ? INC_LO : INC_HI)))
    else $error("oscillator step does not match line frequency select");
  ext_tick_a: assert property ( // (R5)
    tif.ext_sel && $past(tif.ext_sel) && !$past(tif.restart) && $changed(div_q)
      |-> $past(ext_s2_q & ~ext_s3_q))
    else $error("divider advanced without an external clock edge");
  mod_div_a: assert property ( // (R8)
    tick_q |-> $past(div_q) == DIV_LAST && div_q == 4'h0)
    else $error("modulator tick not at tenth system tick");
  conv_len_a: assert property ( // (R12)
    done_q |-> $past(per_q) == $past(target) - 18'h1)
    else $error("conversion ended at wrong length");
endmodule // arcc_timebase

/* design/arcc_top.sv */
// Purpose: converter rate, clock and configuration control with serial port and aux pins
// Assumes: serial and aux pins are asynchronous; filter_result is on pclk
// Notes: registers over APB, zero wait states
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "arcc_cfg.svh"

// Contract
// (R1) Serial data input sampled on each serial clock rising edge while selected.
// (R2) Ready/data output line changes only on serial clock falling edges; the code also sets it one cycle after select falls.
// (R3) Ready/data line low means a fresh result waits; high means none.
// (R4) Host holds select low during any transaction, high otherwise.
// (R5) External timebase select uses the clock pin; host supplies nominal rate.
// (R6) Other external frequencies scale data rate and notches proportionally.
// (R7) Line frequency select 0 gives higher oscillator, 1 gives lower.
// (R8) Modulator clock is system clock divided by ten.
// (R9) Input buffer enable bit in control register one drives the buffer.
// (R10) Polarity bit chooses unipolar or bipolar transfer function.
// (R11) Continuous codes 100..111 give 60..480 or 50..400 sps.
// (R12) Single-cycle codes 000..111 give 1..120 sps, scaled at lower oscillator.
// (R13) Four aux pins with register-controlled direction and level.
// (R14) Single-cycle select picks one-shot conversion with no data latency.
// (R15) Continuous mode needs three more conversions to settle after a step.
module arcc_top #(
  parameter int RATE_SHIFT = 0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [`ARCC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic rdy_dout_o,
  output logic rdy_dout_oe_n,
  // external timebase pin
  input wire logic ext_clk,
  // aux pins, bit 0 is aux_pin_one up to bit 3 aux_pin_four
  input wire logic [`ARCC_AUX_N-1:0] aux_pin_in,
  output logic [`ARCC_AUX_N-1:0] aux_pin_out,
  output logic [`ARCC_AUX_N-1:0] aux_pin_oe_n,
  // filter and analog side
  input wire logic [`ARCC_RES_BITS-1:0] filter_result,
  output logic input_buffer_en,
  output logic unipolar_sel,
  output logic mod_tick,
  // interrupt
  output logic irq
);
  arcc_time_if tif ();

  arcc_pkg::arcc_ctrl_t ctrl_q, ctrl_d;
  arcc_pkg::arcc_rate_t rate_q, rate_d;
  logic run_q, run_d, restart_q, restart_d;
  logic [`ARCC_STS_W-1:0] sts_q, sts_d, mask_q, mask_d, sts_set;
  logic [`ARCC_RES_BITS-1:0] result_q, result_d, tx_sh_q, tx_sh_d;
  logic rdy_q, rdy_d;
  logic [1:0] settle_q, settle_d;
  logic [`ARCC_AUX_N-1:0] dir_q, dir_d, lvl_q, lvl_d, aux_s1_q, aux_s2_q;
  logic [31:0] prdata_q, prdata_d;
  logic cs_s1_q, cs_s2_q, cs_s3_q, sclk_s1_q, sclk_s2_q, sclk_s3_q, din_s1_q, din_s2_q;
  logic [`ARCC_RX_BITS-1:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic [4:0] tx_cnt_q, tx_cnt_d;
  logic dout_q, dout_d;
  logic wr_en, rd_setup, hit, sel_fall, sck_rise, sck_fall, read_done;

  arcc_timebase #(
    .RATE_SHIFT(RATE_SHIFT)
  ) u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .ext_clk(ext_clk),
    .tif(tif)
  );

  assign tif.ext_sel = ctrl_q.ext_timebase_sel;
  assign tif.line_sel = ctrl_q.line_freq_sel;
  assign tif.single_sel = ctrl_q.single_conv_sel;
  assign tif.rate = rate_q;
  assign tif.run = run_q;
  assign tif.restart = restart_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  always_comb begin
    hit = 1'b1;
    case (paddr)
      `ARCC_OFF_CTRL, `ARCC_OFF_CMD, `ARCC_OFF_STATUS, `ARCC_OFF_MASK,
      `ARCC_OFF_DATA, `ARCC_OFF_AUXDIR, `ARCC_OFF_AUXOUT, `ARCC_OFF_AUXIN,
      `ARCC_OFF_SERIAL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    wr_en = psel && penable && pwrite && hit;
    rd_setup = psel && !penable && !pwrite;
    // read data is captured in the setup cycle so it is a flop in the access cycle
    prdata_d = prdata_q;
    if (rd_setup) begin
      case (paddr)
        `ARCC_OFF_CTRL: prdata_d = 32'(ctrl_q);
        `ARCC_OFF_CMD: prdata_d = 32'({run_q, rate_q});
        `ARCC_OFF_STATUS: prdata_d = 32'(sts_q);
        `ARCC_OFF_MASK: prdata_d = 32'(mask_q);
        `ARCC_OFF_DATA: prdata_d = 32'(result_q);
        `ARCC_OFF_AUXDIR: prdata_d = 32'(dir_q);
        `ARCC_OFF_AUXOUT: prdata_d = 32'(lvl_q);
        `ARCC_OFF_AUXIN: prdata_d = 32'(aux_s2_q);
        `ARCC_OFF_SERIAL: prdata_d = 32'({settle_q, rdy_q, rx_byte_q});
        default: prdata_d = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // configuration and conversion control
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    rate_d = rate_q;
    run_d = run_q;
    restart_d = 1'b0;
    dir_d = dir_q;
    lvl_d = lvl_q;
    mask_d = mask_q;
    // (R9) (R10) control register one fields
    if (wr_en && paddr == `ARCC_OFF_CTRL) begin
      ctrl_d = arcc_pkg::arcc_ctrl_t'(pwdata[`ARCC_CTRL_W-1:0]);
      restart_d = run_q;
    end
    if (wr_en && paddr == `ARCC_OFF_CMD) begin
      rate_d = pwdata[2:0];
      run_d = pwdata[`ARCC_CMD_START_BIT];
      restart_d = pwdata[`ARCC_CMD_START_BIT];
    end
    // (R14) one-shot ends after its single period
    if (tif.conv_done && ctrl_q.single_conv_sel && !restart_d) begin
      run_d = 1'b0;
    end
    // (R13) aux pin direction and level
    if (wr_en && paddr == `ARCC_OFF_AUXDIR) begin
      dir_d = pwdata[`ARCC_AUX_N-1:0];
    end
    if (wr_en && paddr == `ARCC_OFF_AUXOUT) begin
      lvl_d = pwdata[`ARCC_AUX_N-1:0];
    end
    if (wr_en && paddr == `ARCC_OFF_MASK) begin
      mask_d = pwdata[`ARCC_STS_W-1:0];
    end
  end

  // ----------------------------------------
  // result, settling and status
  // ----------------------------------------
  always_comb begin
    result_d = result_q;
    rdy_d = rdy_q;
    settle_d = settle_q;
    sts_set = '0;
    // (R15) discard results until the filter has settled
    if (restart_d) begin
      settle_d = ctrl_d.single_conv_sel ? 2'h0 : 2'(`ARCC_SETTLE_CONV);
    end else if (tif.conv_done && settle_q != 2'h0) begin
      settle_d = settle_q - 2'h1;
    end
    if (read_done || restart_d) begin
      rdy_d = 1'b0;
    end
    // (R14) single-cycle result is ready at once; set beats a read clear, restart beats set
    if (tif.conv_done && settle_q == 2'h0 && !restart_d) begin
      result_d = filter_result;
      rdy_d = 1'b1;
      sts_set[`ARCC_STS_CONV] = 1'b1;
    end
    sts_set[`ARCC_STS_RX] = sck_rise && !cs_s2_q && rx_cnt_q == 3'h7;
    sts_d = sts_q;
    if (wr_en && paddr == `ARCC_OFF_STATUS) begin
      sts_d = sts_q & ~pwdata[`ARCC_STS_W-1:0];
    end
    sts_d = sts_d | sts_set;
  end

  // ----------------------------------------
  // serial port
  // ----------------------------------------
  always_comb begin
    sel_fall = !cs_s2_q && cs_s3_q;
    sck_rise = sclk_s2_q && !sclk_s3_q;
    sck_fall = !sclk_s2_q && sclk_s3_q;
    rx_sh_d = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rx_byte_d = rx_byte_q;
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    dout_d = dout_q;
    read_done = 1'b0;
    if (cs_s2_q) begin
      rx_cnt_d = 3'h0;
      tx_cnt_d = 5'h0;
    end else if (sel_fall) begin
      // (R3) line shows ready low as soon as selected
      tx_sh_d = result_q;
      dout_d = !rdy_q;
    end else begin
      // (R1) shift input on serial clock rise
      if (sck_rise) begin
        rx_sh_d = {rx_sh_q[`ARCC_RX_BITS-2:0], din_s2_q};
        rx_cnt_d = rx_cnt_q + 3'h1;
        if (rx_cnt_q == 3'h7) begin
          rx_byte_d = {rx_sh_q[`ARCC_RX_BITS-2:0], din_s2_q};
        end
      end
      // (R2) after the select cycle, output moves only on serial clock fall
      if (sck_fall) begin
        dout_d = tx_sh_q[`ARCC_RES_BITS-1];
        tx_sh_d = {tx_sh_q[`ARCC_RES_BITS-2:0], 1'b0};
        tx_cnt_d = tx_cnt_q + 5'h1;
        read_done = tx_cnt_q == 5'(`ARCC_RES_BITS - 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= arcc_pkg::arcc_ctrl_t'(`ARCC_CTRL_RST);
      rate_q <= 3'h0;
      run_q <= 1'b0;
      restart_q <= 1'b0;
      sts_q <= '0;
      mask_q <= '0;
      result_q <= '0;
      rdy_q <= 1'b0;
      settle_q <= 2'h0;
      dir_q <= '0;
      lvl_q <= '0;
      aux_s1_q <= '0;
      aux_s2_q <= '0;
      prdata_q <= 32'h0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      rx_sh_q <= '0;
      rx_cnt_q <= 3'h0;
      rx_byte_q <= '0;
      tx_sh_q <= '0;
      tx_cnt_q <= 5'h0;
      dout_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      rate_q <= rate_d;
      run_q <= run_d;
      restart_q <= restart_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      result_q <= result_d;
      rdy_q <= rdy_d;
      settle_q <= settle_d;
      dir_q <= dir_d;
      lvl_q <= lvl_d;
      aux_s1_q <= aux_pin_in;
      aux_s2_q <= aux_s1_q;
      prdata_q <= prdata_d;
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      din_s1_q <= din;
      din_s2_q <= din_s1_q;
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_byte_q <= rx_byte_d;
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      dout_q <= dout_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel && penable && !hit;
  assign rdy_dout_o = dout_q;
  // (R4) line released while host leaves select high
  assign rdy_dout_oe_n = cs_s2_q;
  assign aux_pin_out = lvl_q;
  assign aux_pin_oe_n = ~dir_q;
  assign input_buffer_en = ctrl_q.input_buffer_en;
  assign unipolar_sel = ctrl_q.unipolar_sel;
  assign mod_tick = tif.mod_tick;
  assign irq = |(sts_q & mask_q);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sel_low;
    !cs_s2_q && !sel_fall;
  endsequence
  sequence s_ctrl_write;
    wr_en && paddr == `ARCC_OFF_CTRL;
  endsequence

  din_sample_a: assert property ( // (R1)
    s_sel_low ##0 sck_rise |=> rx_sh_q[0] == $past(din_s2_q))
    else $error("serial input not shifted on clock rise");
  dout_edge_a: assert property ( // (R2)
    $changed(rdy_dout_o) && !$past(sel_fall) |-> $past(sck_fall))
    else $error("output line moved without a serial clock fall");
  ready_low_a: assert property ( // (R3)
    sel_fall |=> rdy_dout_o == !$past(rdy_q))
    else $error("ready level wrong at select");
  buffer_bit_a: assert property ( // (R9)
    s_ctrl_write |=> input_buffer_en == $past(pwdata[4]))
    else $error("input buffer enable did not follow write");
  polarity_bit_a: assert property ( // (R10)
    s_ctrl_write |=> unipolar_sel == $past(pwdata[1]))
    else $error("polarity select did not follow write");
  aux_dir_a: assert property ( // (R13)
    wr_en && paddr == `ARCC_OFF_AUXDIR |=> aux_pin_oe_n == ~$past(pwdata[3:0]))
    else $error("aux pin direction did not follow write");
  oneshot_stop_a: assert property ( // (R14)
    tif.conv_done && ctrl_q.single_conv_sel && !restart_d |=> !run_q && rdy_q)
    else $error("single-cycle conversion did not stop with a result");
  settle_gate_a: assert property ( // (R15)
    $rose(rdy_q) |-> $past(settle_q) == 2'h0 && $past(tif.conv_done))
    else $error("result flagged before settling");
  settle_load_a: assert property ( // (R15)
    restart_q && !ctrl_q.single_conv_sel ##0 !tif.conv_done [*2]
      |-> settle_q == 2'(`ARCC_SETTLE_CONV))
    else $error("settle count not loaded on continuous restart");
endmodule // arcc_top

/* tb/arcc_host_model.sv */
// Purpose: host model that masters the serial port of the rate and clock block
// Assumes: pclk 125 MHz; one sclk half period is 6 pclk, above the 3 pclk minimum
// Notes: sclk idles high and stands still between frames; din inverts when released
`timescale 1ns/10ps
module arcc_host_model (
  // clock
  input wire logic pclk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic rdy_line
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end

  task automatic half();
    repeat (6) @(posedge pclk);
  endtask

  task automatic sel(input logic v);
    cs_n <= v;
    half();
  endtask

  // bit set up before the rise
  task automatic send_byte(input logic [7:0] b);
    sel(1'b0);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      din <= b[i];
      half();
      sclk <= 1'b1;
      half();
    end
    din <= ~b[0];
    sel(1'b1);
  endtask

  // ready level, then bits taken at each rise
  task automatic read_word(output logic rdy, output logic [23:0] w);
    sel(1'b0);
    rdy = rdy_line;
    for (int i = 23; i >= 0; i--) begin
      sclk <= 1'b0;
      half();
      sclk <= 1'b1;
      w[i] = rdy_line;
      half();
    end
    sel(1'b1);
  endtask
endmodule // arcc_host_model

/* tb/testbench.sv */
// Purpose: self-checking bench of the rate and clock block
// Assumes: RATE_SHIFT 8 so a single-cycle rate-7 run is 80 system ticks
// Notes: ext_clk period is 40 pclk, i.e. one modulator tick per 400 pclk
`timescale 1ns/10ps
`include "arcc_cfg.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cs_n, sclk, din, rdy_dout_o, rdy_dout_oe_n, rdy_line, err;
  logic ext_clk = 1'b0;
  logic [3:0] aux_ext = 4'h0;
  logic [3:0] aux_in, aux_pin_out, aux_pin_oe_n;
  logic [23:0] filter_result = 24'hC3A51E;
  logic input_buffer_en, unipolar_sel, mod_tick, irq;
  int failures = 0;
  int n_compared = 0;

  always #4 pclk = ~pclk;
  always begin
    repeat (20) @(posedge pclk);
    ext_clk <= ~ext_clk;
  end
  assign rdy_line = rdy_dout_oe_n ? 1'b1 : rdy_dout_o;
  assign aux_in = (~aux_pin_oe_n & aux_pin_out) | (aux_pin_oe_n & aux_ext);

  arcc_top #(.RATE_SHIFT(8)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din),
    .rdy_dout_o(rdy_dout_o), .rdy_dout_oe_n(rdy_dout_oe_n), .ext_clk(ext_clk),
    .aux_pin_in(aux_in), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n),
    .filter_result(filter_result), .input_buffer_en(input_buffer_en),
    .unipolar_sel(unipolar_sel), .mod_tick(mod_tick), .irq(irq));
  arcc_host_model i_host (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .rdy_line(rdy_line));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // an idle edge first, so psel is never set twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the written flops settle before the caller looks at outputs
    @(posedge pclk);
  endtask

  task automatic irq_wait(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic tick_gap(output int n);
    n = 0;
    while (mod_tick !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mod_tick !== 1'b1 && n < 2000);
  endtask

  task automatic finish_test();
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_ctrl();
    logic [31:0] d;
    check(32'({aux_pin_oe_n, aux_pin_out, irq, input_buffer_en, unipolar_sel}), 32'h780);
    apb(1'b1, `ARCC_OFF_CTRL, 32'h10, d);
    check(32'({input_buffer_en, unipolar_sel}), 32'h2);
    apb(1'b1, `ARCC_OFF_CTRL, 32'h02, d);
    check(32'({input_buffer_en, unipolar_sel}), 32'h1);
    apb(1'b0, `ARCC_OFF_CTRL, 32'h0, d);
    check(d, 32'h2);
    apb(1'b0, 8'h40, 32'h0, d);
    check({d[30:0], err}, 32'h1);
  endtask

  task automatic t_aux();
    logic [31:0] d;
    aux_ext <= 4'hA;
    apb(1'b1, `ARCC_OFF_AUXDIR, 32'h5, d);
    apb(1'b1, `ARCC_OFF_AUXOUT, 32'h1, d);
    check(32'({aux_pin_oe_n, aux_pin_out}), 32'hA1);
    repeat (3) @(posedge pclk);
    apb(1'b0, `ARCC_OFF_AUXIN, 32'h0, d);
    check(d, 32'hB);
  endtask

  task automatic t_serial_in();
    logic [31:0] d;
    apb(1'b1, `ARCC_OFF_MASK, 32'h3, d);
    i_host.send_byte(8'hA5);
    apb(1'b0, `ARCC_OFF_SERIAL, 32'h0, d);
    check(d & 32'hFF, 32'hA5);
    check(32'(irq), 32'h1);
    apb(1'b1, `ARCC_OFF_STATUS, 32'h2, d);
    check(32'(irq), 32'h0);
  endtask

  // single-cycle, rate 7, both oscillators: 80 ticks of ~50.9 or ~61.0 pclk
  task automatic t_single();
    logic [31:0] d;
    logic [23:0] w;
    logic rdy;
    int n;
    for (int lf = 0; lf < 2; lf++) begin
      apb(1'b1, `ARCC_OFF_CTRL, 32'h08 | 32'(lf), d);
      apb(1'b1, `ARCC_OFF_CMD, 32'hF, d);
      irq_wait(n);
      check(32'(lf == 0 ? (n inside {[4000:4150]}) : (n inside {[4800:4980]})), 32'h1);
      apb(1'b0, `ARCC_OFF_DATA, 32'h0, d);
      check(d, 32'(filter_result));
      i_host.read_word(rdy, w);
      check({7'h0, rdy, w}, 32'(filter_result));
      i_host.read_word(rdy, w);
      check(32'(rdy), 32'h1);
      apb(1'b1, `ARCC_OFF_CMD, 32'h0, d);
      apb(1'b1, `ARCC_OFF_STATUS, 32'h3, d);
    end
  endtask

  // continuous rate 7: 3 dropped runs of 20 ticks, then one result per run
  task automatic t_cont();
    logic [31:0] d;
    int n;
    apb(1'b1, `ARCC_OFF_CTRL, 32'h0, d);
    apb(1'b1, `ARCC_OFF_CMD, 32'hF, d);
    irq_wait(n);
    check(32'(n inside {[4000:4150]}), 32'h1);
    apb(1'b1, `ARCC_OFF_STATUS, 32'h1, d);
    irq_wait(n);
    check(32'(n inside {[950:1060]}), 32'h1);
    tick_gap(n);
    check(32'(n inside {[506:511]}), 32'h1);
    apb(1'b1, `ARCC_OFF_CTRL, 32'h04, d);
    tick_gap(n);
    tick_gap(n);
    check(32'(n inside {[398:402]}), 32'h1);
    apb(1'b1, `ARCC_OFF_CMD, 32'h0, d);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_ctrl();
    t_aux();
    t_serial_in();
    t_single();
    t_cont();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule // testbench
